// File: hw/uef_defines.svh
// uef_defines.svh: offsets, bit positions and reset values of the usb event flags.
// assumes a 32-bit axi4-lite slave, one register per aligned word.
`ifndef UEF_DEFINES_SVH
`define UEF_DEFINES_SVH

// ======================================================================
// register byte offsets
`define UEF_OFS_FLAGS0   8'h00
`define UEF_OFS_FLAGS1   8'h04
`define UEF_OFS_ENABLE0  8'h08
`define UEF_OFS_ENABLE1  8'h0C
`define UEF_OFS_CONTROL  8'h10

// ======================================================================
// usb_event_flags_0 bit positions
`define UEF_F0_CTL_IN_DONE   0
`define UEF_F0_CTL_IN_REQ    1
`define UEF_F0_CTL_OUT_DONE  2
`define UEF_F0_SETUP_DONE    3
`define UEF_F0_BULK_FREE     4
`define UEF_F0_RST           8'h10
`define UEF_F0_CLEARABLE     8'h0F

// ======================================================================
// usb_event_flags_1 bit positions
`define UEF_F1_ATTACH_CHG    0
`define UEF_F1_INTR_DONE     1
`define UEF_F1_INTR_REQ      2
`define UEF_F1_POWER_LVL     3
`define UEF_F1_RST           8'h00
`define UEF_F1_CLEARABLE     8'h07
`define UEF_F1_IRQ_CAPABLE   8'h07

// ======================================================================
// control register bit positions
`define UEF_CTL_PULLUP_EN    0
`define UEF_CTL_EP0_ARM      1
`define UEF_CTL_EP3_ARM      2
`define UEF_CTL_RST          8'h00

// ======================================================================
// axi response codes
`define UEF_RESP_OKAY        2'h0
`define UEF_RESP_SLVERR      2'h2

`endif

// File: hw/uef_event_flags.sv
// uef_event_flags.sv: usb device event flags, enables and in-token replies,
// behind an axi4-lite register slave.
// assumes usb engine events are synchronous to aclk; cable power sense is async.
`timescale 1ns/1ps
`include "uef_defines.svh"

module uef_event_flags
   import uef_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   input  wire logic                aclk,
   input  wire logic                aresetn,
   // axi4-lite slave
   input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
   input  wire logic                s_axi_awvalid,
   output logic                     s_axi_awready,
   input  wire logic [31:0]         s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   input  wire logic                s_axi_wvalid,
   output logic                     s_axi_wready,
   output logic [1:0]               s_axi_bresp,
   output logic                     s_axi_bvalid,
   input  wire logic                s_axi_bready,
   input  wire logic [ADDR_W-1:0]   s_axi_araddr,
   input  wire logic                s_axi_arvalid,
   output logic                     s_axi_arready,
   output logic [31:0]              s_axi_rdata,
   output logic [1:0]               s_axi_rresp,
   output logic                     s_axi_rvalid,
   input  wire logic                s_axi_rready,
   // usb engine side
   input  wire uef_usb_evt_t        usb_evt,
   input  wire logic                cable_power_pin,
   output uef_in_reply_t            in_reply,
   output logic                     pullup_en,
   // interrupt requests per flag register
   output logic                     irq0,
   output logic                     irq1
);

   // ======================================================================
   // functions

   // true when an in token finds no armed packet
   function automatic logic empty_token(input logic token, input logic armed);
      return token & ~armed;
   endfunction

   // next flag value: keep bits written 1, clear bits written 0, set wins
   // set wins so that an event landing on a clear in the same cycle is never lost
   function automatic logic [7:0] flag_next(input logic [7:0] cur,
                                            input logic       wr,
                                            input logic [7:0] wdat,
                                            input logic [7:0] clr_ok,
                                            input logic [7:0] set);
      logic [7:0] keep;
      keep = wr ? (wdat | ~clr_ok) : 8'hFF;
      return (cur & keep) | set;
   endfunction

   // ======================================================================
   // declarations
   logic [7:0]        flags0_q;
   logic [7:0]        flags0_d;
   logic [7:0]        flags1_q;
   logic [7:0]        flags1_d;
   logic [7:0]        enable0_q;
   logic [7:0]        enable1_q;
   logic [7:0]        control_q;
   logic              ep0_armed_q;
   logic              ep3_armed_q;
   logic              power_meta_q;
   logic              power_sync_q;
   logic              power_prev_q;
   logic [ADDR_W-1:0] awaddr_q;
   logic [31:0]       wdata_q;
   logic [3:0]        wstrb_q;
   logic              do_write;
   logic              wr_lane0;
   logic              wr_flags0;
   logic              wr_flags1;
   logic              wr_control;
   logic              wr_map_ok;
   logic [7:0]        set0;
   logic [7:0]        set1;
   logic [7:0]        power_bit;
   logic [7:0]        rd_byte;
   logic              rd_map_ok;

   // ======================================================================
   // axi write channel

   // address and data are taken independently, then the write is applied once
   // the write lands two cycles after the later handshake, together with bvalid
   // both readies stay low until the response is taken: one write at a time
   assign do_write  = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
   assign wr_lane0  = do_write & wstrb_q[0];
   assign wr_map_ok = (awaddr_q == `UEF_OFS_FLAGS0)  || (awaddr_q == `UEF_OFS_FLAGS1) ||
                      (awaddr_q == `UEF_OFS_ENABLE0) || (awaddr_q == `UEF_OFS_ENABLE1) ||
                      (awaddr_q == `UEF_OFS_CONTROL);
   assign wr_flags0  = wr_lane0 && (awaddr_q == `UEF_OFS_FLAGS0);
   assign wr_flags1  = wr_lane0 && (awaddr_q == `UEF_OFS_FLAGS1);
   assign wr_control = wr_lane0 && (awaddr_q == `UEF_OFS_CONTROL);

   // write address handshake
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         awaddr_q      <= '0;
      end else if (s_axi_awready && s_axi_awvalid) begin
         s_axi_awready <= 1'b0;
         awaddr_q      <= s_axi_awaddr & ~ADDR_W'(3);
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_awready <= 1'b1;
      end
   end

   // write data handshake
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_wready <= 1'b1;
         wdata_q      <= '0;
         wstrb_q      <= '0;
      end else if (s_axi_wready && s_axi_wvalid) begin
         s_axi_wready <= 1'b0;
         wdata_q      <= s_axi_wdata;
         wstrb_q      <= s_axi_wstrb;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_wready <= 1'b1;
      end
   end

   // write response, slverr for an unmapped address
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `UEF_RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_map_ok ? `UEF_RESP_OKAY : `UEF_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ======================================================================
   // cable power sense synchroniser and edge memory

   // two stages before any logic looks at the pin
   // the pin is asynchronous, so logic reads only power_sync_q and power_prev_q
   // power_prev_q keeps the last synchronised level for edge detection
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         power_meta_q <= 1'b0;
         power_sync_q <= 1'b0;
         power_prev_q <= 1'b0;
      end else begin
         power_meta_q <= cable_power_pin;
         power_sync_q <= power_meta_q;
         power_prev_q <= power_sync_q;
      end
   end

   // ======================================================================
   // enables and control

   // enable registers, byte lane 0 only
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         enable0_q <= '0;
         enable1_q <= '0;
      end else if (wr_lane0 && awaddr_q == `UEF_OFS_ENABLE0) begin
         enable0_q <= wdata_q[7:0];
      end else if (wr_lane0 && awaddr_q == `UEF_OFS_ENABLE1) begin
         enable1_q <= wdata_q[7:0];
      end
   end

   // control register holds the pull-up enable
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         control_q <= `UEF_CTL_RST;
      end else if (wr_control) begin
         control_q <= {7'h00, wdata_q[`UEF_CTL_PULLUP_EN]};
      end
   end

   // packet armed by firmware, disarmed once the host acks it
   // an ack in the cycle of an arm write wins: the packet just sent is gone,
   // and firmware arms again for the next one
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ep0_armed_q <= 1'b0;
         ep3_armed_q <= 1'b0;
      end else begin
         if (usb_evt.ep0_in_acked) begin
            ep0_armed_q <= 1'b0;
         end else if (wr_control && wdata_q[`UEF_CTL_EP0_ARM]) begin
            ep0_armed_q <= 1'b1;
         end
         if (usb_evt.ep3_in_acked) begin
            ep3_armed_q <= 1'b0;
         end else if (wr_control && wdata_q[`UEF_CTL_EP3_ARM]) begin
            ep3_armed_q <= 1'b1;
         end
      end
   end

   // answer each in token: nak while nothing is armed
   // a token that finds the buffer armed is answered with the packet instead
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         in_reply <= '0;
      end else begin
         in_reply.ep0_nak  <= empty_token(usb_evt.ep0_in_token, ep0_armed_q);
         in_reply.ep0_send <= usb_evt.ep0_in_token & ep0_armed_q;
         in_reply.ep3_nak  <= empty_token(usb_evt.ep3_in_token, ep3_armed_q);
         in_reply.ep3_send <= usb_evt.ep3_in_token & ep3_armed_q;
      end
   end

   // pull-up drive follows the control bit
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pullup_en <= 1'b0;
      end else begin
         pullup_en <= control_q[`UEF_CTL_PULLUP_EN];
      end
   end

   // ======================================================================
   // flag set sources
   // request flags share the nak decode, so flag and reply never disagree
   always_comb begin
      set0 = '0;
      set0[`UEF_F0_SETUP_DONE]   = usb_evt.setup_acked;
      set0[`UEF_F0_CTL_OUT_DONE] = usb_evt.ctl_out_acked;
      set0[`UEF_F0_CTL_IN_REQ]   = empty_token(usb_evt.ep0_in_token, ep0_armed_q);
      set0[`UEF_F0_CTL_IN_DONE]  = usb_evt.ep0_in_acked;
      set1 = '0;
      set1[`UEF_F1_INTR_REQ]     = empty_token(usb_evt.ep3_in_token, ep3_armed_q);
      set1[`UEF_F1_INTR_DONE]    = usb_evt.ep3_in_acked;
      set1[`UEF_F1_ATTACH_CHG]   = power_sync_q ^ power_prev_q;
   end

   // status bit: live power level, masked by the pull-up enable
   // attach detection uses the unmasked synchronised level instead
   always_comb begin
      power_bit = '0;
      power_bit[`UEF_F1_POWER_LVL] = power_sync_q &
                                     control_q[`UEF_CTL_PULLUP_EN];
   end

   // next flag values, reserved bits forced to zero
   always_comb begin
      flags0_d = flag_next(flags0_q, wr_flags0, wdata_q[7:0],
                           `UEF_F0_CLEARABLE, set0) & `UEF_F0_CLEARABLE;
      flags0_d[`UEF_F0_BULK_FREE] = |usb_evt.ep2_buf_free;
      flags1_d = (flag_next(flags1_q, wr_flags1, wdata_q[7:0],
                            `UEF_F1_CLEARABLE, set1) & `UEF_F1_CLEARABLE)
                 | power_bit;
   end

   // ======================================================================
   // flag registers
   // bulk free resets to 1, then follows the endpoint 2 buffers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flags0_q <= `UEF_F0_RST;
         flags1_q <= `UEF_F1_RST;
      end else begin
         flags0_q <= flags0_d;
         flags1_q <= flags1_d;
      end
   end

   // interrupt requests; the power status bit never requests
   // taken from the next flag value so a request rises with its flag
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq0 <= 1'b0;
         irq1 <= 1'b0;
      end else begin
         irq0 <= |(flags0_d & enable0_q);
         irq1 <= |(flags1_d & enable1_q & `UEF_F1_IRQ_CAPABLE);
      end
   end

   // ======================================================================
   // axi read channel

   // read multiplexer on the requested address
   // unmapped offsets read zero and answer with slverr
   always_comb begin
      rd_byte   = '0;
      rd_map_ok = 1'b1;
      unique case (s_axi_araddr & ~ADDR_W'(3))
         `UEF_OFS_FLAGS0:  rd_byte = flags0_q;
         `UEF_OFS_FLAGS1:  rd_byte = flags1_q;
         `UEF_OFS_ENABLE0: rd_byte = enable0_q;
         `UEF_OFS_ENABLE1: rd_byte = enable1_q;
         `UEF_OFS_CONTROL: rd_byte = {5'h00, ep3_armed_q, ep0_armed_q,
                                      control_q[`UEF_CTL_PULLUP_EN]};
         default:          rd_map_ok = 1'b0;
      endcase
   end

   // read handshake, answer one cycle after the address is taken
   // arready stays low while rvalid stands: one read at a time
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= `UEF_RESP_OKAY;
      end else if (s_axi_arready && s_axi_arvalid) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= {24'h000000, rd_byte};
         s_axi_rresp   <= rd_map_ok ? `UEF_RESP_OKAY : `UEF_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
      end
   end

endmodule

// File: hw/uef_pkg.sv
// uef_pkg.sv: types shared by the usb event flag block.
// assumes the protocol engine delivers events as one-cycle pulses on aclk.
package uef_pkg;

   // ======================================================================
   // events and levels reported by the usb protocol engine
   typedef struct packed {
      logic       setup_acked;     // setup request taken and acked
      logic       ctl_out_acked;   // control-out data stored and acked
      logic       ep0_in_token;    // in token for endpoint 0
      logic       ep0_in_acked;    // endpoint 0 packet acked by host
      logic       ep3_in_token;    // in token for endpoint 3
      logic       ep3_in_acked;    // endpoint 3 packet acked by host
      logic [1:0] ep2_buf_free;    // each endpoint 2 transmit buffer free
   } uef_usb_evt_t;

   // ======================================================================
   // answers to in tokens
   typedef struct packed {
      logic ep0_nak;               // nak endpoint 0 token
      logic ep0_send;              // send armed endpoint 0 packet
      logic ep3_nak;               // nak endpoint 3 token
      logic ep3_send;              // send armed endpoint 3 packet
   } uef_in_reply_t;

endpackage

// File: verification/tb.sv
// tb.sv: register-level bench for the usb event flag block.
// assumes uef_event_flags, uef_usb_host_model and the bound checker.
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
   $display("Error %s exp %0h got %0h", n, e, g); end end
module tb;
   import uef_pkg::*;
   logic          aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   logic          s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
   logic          s_axi_bvalid, s_axi_arready, s_axi_rvalid, pullup_en, irq0, irq1;
   logic          cable_power_pin;
   logic [7:0]    s_axi_awaddr, s_axi_araddr;
   logic [31:0]   s_axi_wdata, s_axi_rdata;
   logic [3:0]    s_axi_wstrb;
   logic [1:0]    s_axi_bresp, s_axi_rresp;
   uef_usb_evt_t  usb_evt;
   uef_in_reply_t in_reply;
   int            mismatches = 0;
   int            cmp_count = 0;

   uef_event_flags #(.ADDR_W(8)) u_dut (.*);
   uef_usb_host_model u_host (.aclk(aclk), .usb_evt(usb_evt), .cable_power_pin(cable_power_pin));

   // ====================
   // 25 mhz clock
   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end

   // ====================
   // axi4-lite write, address and data offered together
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
      logic aw, w;
      aw = 1'b1;
      w = 1'b1;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (aw && s_axi_awready) begin
            aw = 1'b0;
            s_axi_awvalid <= 1'b0;
         end
         if (w && s_axi_wready) begin
            w = 1'b0;
            s_axi_wvalid <= 1'b0;
         end
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      `CHK("bresp", er, s_axi_bresp)
   endtask

   // axi4-lite read with compare of byte and response
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er,
                     input string n);
      logic ar;
      ar = 1'b1;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (ar && s_axi_arready) begin
            ar = 1'b0;
            s_axi_arvalid <= 1'b0;
         end
      end while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      `CHK(n, {24'h0, e}, s_axi_rdata)
      `CHK("rresp", er, s_axi_rresp)
   endtask

   // engine pulse, then let the edge's updates land
   task automatic ev(input int b);
      u_host.pulse(b, 0);
      #1;
   endtask

   task automatic tally_and_finish();
      if (mismatches == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // ====================
   // main sequence
   initial begin
      aresetn = 1'b0;
      s_axi_awvalid = 1'b0;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b0;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b0;
      s_axi_awaddr = 8'h00;
      s_axi_araddr = 8'h00;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hF;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rd(8'h00, 8'h10, 2'h0, "flags0");
      rd(8'h04, 8'h00, 2'h0, "flags1");
      u_host.free(2'b00);
      rd(8'h00, 8'h00, 2'h0, "flags0");
      u_host.free(2'b10);
      wr(8'h00, 8'h00, 2'h0);
      rd(8'h00, 8'h10, 2'h0, "flags0");
      ev(7);
      ev(6);
      ev(5);
      `CHK("reply", 4'h8, in_reply)
      u_host.pulse(4, 3);
      rd(8'h00, 8'h1F, 2'h0, "flags0");
      wr(8'h00, 8'hF5, 2'h0);
      rd(8'h00, 8'h15, 2'h0, "flags0");
      wr(8'h00, 8'hFA, 2'h0);
      wr(8'h08, 8'h01, 2'h0);
      rd(8'h08, 8'h01, 2'h0, "enable0");
      ev(4);
      `CHK("irq0", 1'b1, irq0)
      wr(8'h00, 8'hFE, 2'h0);
      rd(8'h00, 8'h10, 2'h0, "flags0");
      `CHK("irq0", 1'b0, irq0)
      wr(8'h08, 8'h00, 2'h0);
      ev(4);
      `CHK("irq0", 1'b0, irq0)
      wr(8'h00, 8'hFE, 2'h0);
      wr(8'h10, 8'h03, 2'h0);
      ev(5);
      `CHK("reply", 4'h4, in_reply)
      ev(4);
      rd(8'h10, 8'h01, 2'h0, "control");
      rd(8'h00, 8'h11, 2'h0, "flags0");
      fork
         wr(8'h00, 8'hF7, 2'h0);
         u_host.pulse(7, 1);
      join
      rd(8'h00, 8'h19, 2'h0, "flags0");
      u_host.power(1'b1);
      repeat (6) @(posedge aclk);
      rd(8'h04, 8'h09, 2'h0, "flags1");
      wr(8'h0C, 8'h08, 2'h0);
      rd(8'h0C, 8'h08, 2'h0, "enable1");
      `CHK("irq1", 1'b0, irq1)
      wr(8'h10, 8'h00, 2'h0);
      rd(8'h04, 8'h01, 2'h0, "flags1");
      `CHK("pullup", 1'b0, pullup_en)
      wr(8'h04, 8'h00, 2'h0);
      rd(8'h04, 8'h00, 2'h0, "flags1");
      u_host.power(1'b0);
      repeat (6) @(posedge aclk);
      rd(8'h04, 8'h01, 2'h0, "flags1");
      wr(8'h04, 8'h00, 2'h0);
      ev(3);
      `CHK("reply", 4'h2, in_reply)
      u_host.pulse(2, 2);
      rd(8'h04, 8'h06, 2'h0, "flags1");
      wr(8'h0C, 8'h04, 2'h0);
      rd(8'h04, 8'h06, 2'h0, "flags1");
      `CHK("irq1", 1'b1, irq1)
      wr(8'h04, 8'h00, 2'h0);
      wr(8'h10, 8'h05, 2'h0);
      rd(8'h10, 8'h05, 2'h0, "control");
      `CHK("pullup", 1'b1, pullup_en)
      ev(3);
      `CHK("reply", 4'h1, in_reply)
      ev(2);
      rd(8'h10, 8'h01, 2'h0, "control");
      rd(8'h04, 8'h02, 2'h0, "flags1");
      wr(8'h20, 8'hFF, 2'h2);
      rd(8'h20, 8'h00, 2'h2, "unmapped");
      tally_and_finish();
   end

   // hang guard, far beyond the sequence's length
   initial begin
      repeat (3000) @(posedge aclk);
      mismatches++;
      tally_and_finish();
   end
endmodule

// File: verification/uef_checker.sv
// uef_checker.sv: port assertions for the usb event flag block.
// assumes binding to uef_event_flags; one clock, sync active-low reset.
`timescale 1ns/1ps
module uef_checker
   import uef_pkg::*;
(
   input wire logic          aclk,
   input wire logic          aresetn,
   input wire logic          s_axi_awvalid,
   input wire logic          s_axi_awready,
   input wire logic          s_axi_wvalid,
   input wire logic          s_axi_wready,
   input wire logic          s_axi_bvalid,
   input wire logic          s_axi_arvalid,
   input wire logic          s_axi_arready,
   input wire logic          s_axi_rvalid,
   input wire logic [31:0]   s_axi_rdata,
   input wire logic [1:0]    s_axi_rresp,
   input wire uef_usb_evt_t  usb_evt,
   input wire uef_in_reply_t in_reply
);
   // ====================
   // shared clock and reset
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // ====================
   // in-token replies: exactly one answer, only after a token
   property p_tok0;
      usb_evt.ep0_in_token |=> in_reply.ep0_nak != in_reply.ep0_send;
   endproperty
   a_tok0: assert property (p_tok0) else $error("ep0 token answer wrong");
   property p_tok3;
      usb_evt.ep3_in_token |=> in_reply.ep3_nak != in_reply.ep3_send;
   endproperty
   a_tok3: assert property (p_tok3) else $error("ep3 token answer wrong");
   property p_quiet0;
      !usb_evt.ep0_in_token |=> !(in_reply.ep0_nak || in_reply.ep0_send);
   endproperty
   a_quiet0: assert property (p_quiet0) else $error("ep0 answer without token");
   property p_quiet3;
      !usb_evt.ep3_in_token |=> !(in_reply.ep3_nak || in_reply.ep3_send);
   endproperty
   a_quiet3: assert property (p_quiet3) else $error("ep3 answer without token");

   // ====================
   // register bus timing and read data
   property p_wr;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
         |=> !s_axi_bvalid ##1 s_axi_bvalid;
   endproperty
   a_wr: assert property (p_wr) else $error("write answer late");
   property p_rd;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
   endproperty
   a_rd: assert property (p_rd) else $error("read answer late");
   property p_upper;
      s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
   endproperty
   a_upper: assert property (p_upper) else $error("read upper bits set");
   property p_err;
      s_axi_rvalid && s_axi_rresp != 2'h0 |-> s_axi_rdata == 32'h0;
   endproperty
   a_err: assert property (p_err) else $error("error read data not zero");
endmodule

bind uef_event_flags uef_checker u_chk (.*);

// File: verification/uef_usb_host_model.sv
// uef_usb_host_model.sv: usb host stand-in making engine events and cable power.
// assumes the bench calls its tasks; every change follows a rising edge.
`timescale 1ns/1ps
module uef_usb_host_model
   import uef_pkg::*;
(
   input  wire logic    aclk,
   output uef_usb_evt_t usb_evt,
   output logic         cable_power_pin
);
   logic [7:0] ev_q;

   // ====================
   // event bits as the engine struct, msb first
   assign usb_evt = uef_usb_evt_t'(ev_q);

   // one endpoint 2 buffer free at start, power off
   initial begin
      ev_q = 8'h01;
      cable_power_pin = 1'b0;
   end

   // one-cycle token or ack pulse, after a pause of gap cycles
   task automatic pulse(input int b, input int gap);
      repeat (gap) @(posedge aclk);
      @(posedge aclk);
      ev_q[b] <= 1'b1;
      @(posedge aclk);
      ev_q[b] <= 1'b0;
   endtask

   // endpoint 2 buffer free levels
   task automatic free(input logic [1:0] f);
      @(posedge aclk);
      ev_q[1:0] <= f;
   endtask

   // cable power level
   task automatic power(input logic v);
      @(posedge aclk);
      cable_power_pin <= v;
   endtask
endmodule
